// ===== rtc_register_bank.v
// Serial-accessed register bank, divider and reset control of the clock and calendar
// Function
// - Sixteen byte-wide registers for control, time, alarm, offset and timer.
// - Time and date registers hold BCD values in their documented ranges.
// - Unimplemented bits read zero; host writes zero to reserved bits.
// - Main control bit 2 selects 24-hour (0) or 12-hour (1) format.
// - Main control bit 7 selects normal or external clock test mode.
// - Clock-stop halts source clock, clears divider; clock output keeps running only at 32.768, 16.384 and 8.192 kHz.
// - Software reset request bit always reads back as zero.
// - Correction interrupt enable gives a pulse per correction cycle.
// - An internal reset happens whenever power is first applied.
// - Only writing 58h to main control resets; that write stores nothing.
// - After reset: 32.768 kHz clock output, 24-hour format, offset zero.
// - After reset: alarms, countdown timer and all interrupt sources disabled.
// - Countdown source is 4.096 kHz, 64 Hz, 1 Hz or 1/60 Hz.
// - Register address increments after every data byte of a transfer.
// - Time counters freeze while a time or date register is accessed.
// - Alarm flag sets on alarm and stays set until host clears it.
// - Oscillator-stopped flag sets on stop or power-on until software clears it.
`include "rtc_register_map.vh"

module rtc_register_bank (
	input wire core_clk,
	input wire resetn,
	input wire clk_en,
	input wire spi_ce,
	input wire spi_scl,
	input wire spi_sdi,
	output wire sdo_out,
	output wire sdo_oe_n,
	input wire osc_in,
	input wire osc_stopped,
	input wire clkout_pin_enable,
	output wire clkout_out,
	output wire clkout_oe_n,
	input wire time_update,
	input wire [55:0] time_in,
	input wire alarm_event,
	input wire countdown_event,
	input wire tick_event,
	input wire correction_cycle,
	output reg correction_irq_pulse,
	output wire [55:0] time_value,
	output wire counters_frozen,
	output reg software_reset_pulse,
	output wire external_clock_test_select,
	output wire rtc_source_stopped,
	output wire hour_12_mode,
	output wire minute_tick_irq_enable,
	output wire second_tick_irq_enable,
	output wire timer_irq_pulse_select,
	output wire alarm_irq_enable,
	output wire countdown_irq_enable,
	output wire alarm_flag,
	output wire countdown_flag,
	output wire tick_irq_flag,
	output wire [31:0] alarm_match,
	output wire [7:0] frequency_offset,
	output wire [2:0] clock_output_frequency_select,
	output wire countdown_enable,
	output wire [1:0] countdown_source_select,
	output wire [7:0] countdown_value,
	output reg countdown_source_tick,
	output reg second_tick
);

	reg rst_meta;
	reg rst_sync;
	wire rst_n;
	reg [7:0] regs [0:`ADDR_LAST];
	reg [4:0] meta;
	reg ce_s, scl_s, sdi_s, osc_s, cloe_s;
	reg scl_d, osc_d;
	reg [2:0] bit_cnt;
	reg [7:0] in_shift;
	reg [7:0] out_shift;
	reg cmd_phase;
	reg is_read;
	reg [3:0] addr;
	reg sw_reset_pending;
	reg [`DIV_WIDTH-1:0] div_cnt;
	reg [5:0] min_cnt;
	reg [1:0] cko_cnt;
	reg tick_4096, tick_64, tick_1, tick_60;
	reg clk_level;
	wire scl_rise, scl_fall, osc_rise;
	wire [7:0] next_in;
	wire byte_done;
	wire wr_strobe;
	wire is_reset_code;
	integer i;

	// Implemented bits of each register
	function [7:0] reg_mask;
		input [3:0] a;
		begin
			case (a)
				`ADDR_MAIN_CONTROL: reg_mask = `MASK_MAIN_CONTROL;
				`ADDR_MINUTES_COUNT: reg_mask = `MASK_MINUTES;
				`ADDR_HOURS_COUNT: reg_mask = `MASK_HOURS;
				`ADDR_DAY_OF_MONTH_COUNT: reg_mask = `MASK_DAYS;
				`ADDR_DAY_OF_WEEK_COUNT: reg_mask = `MASK_WEEKDAYS;
				`ADDR_MONTH_COUNT: reg_mask = `MASK_MONTHS;
				`ADDR_ALARM_HOUR_MATCH: reg_mask = `MASK_HOUR_ALARM;
				`ADDR_ALARM_DAY_MATCH: reg_mask = `MASK_DAY_ALARM;
				`ADDR_ALARM_DAY_OF_WEEK_MATCH: reg_mask = `MASK_WEEKDAY_ALARM;
				`ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG: reg_mask = `MASK_TIMER_CONFIG;
				default: reg_mask = `MASK_FULL;
			endcase
		end
	endfunction

	// Value forced by a resetn reset, and by a software reset on the bits outside keep_mask
	function [7:0] rst_value;
		input [3:0] a;
		begin
			case (a)
				`ADDR_SECONDS_COUNT: rst_value = `RST_SECONDS;
				`ADDR_ALARM_MINUTE_MATCH: rst_value = `RST_ALARM;
				`ADDR_ALARM_HOUR_MATCH: rst_value = `RST_ALARM;
				`ADDR_ALARM_DAY_MATCH: rst_value = `RST_ALARM;
				`ADDR_ALARM_DAY_OF_WEEK_MATCH: rst_value = `RST_ALARM;
				`ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG: rst_value = `RST_TIMER_CONFIG;
				default: rst_value = `RST_ZERO;
			endcase
		end
	endfunction

	// Bits a software reset leaves as they are
	function [7:0] keep_mask;
		input [3:0] a;
		begin
			case (a)
				`ADDR_MAIN_CONTROL: keep_mask = `KEEP_NONE;
				`ADDR_INTERRUPT_CONTROL_STATUS: keep_mask = `KEEP_NONE;
				`ADDR_SECONDS_COUNT: keep_mask = `KEEP_ALARM;
				`ADDR_ALARM_MINUTE_MATCH: keep_mask = `KEEP_ALARM;
				`ADDR_ALARM_HOUR_MATCH: keep_mask = `KEEP_ALARM;
				`ADDR_ALARM_DAY_MATCH: keep_mask = `KEEP_ALARM;
				`ADDR_ALARM_DAY_OF_WEEK_MATCH: keep_mask = `KEEP_ALARM;
				`ADDR_FREQUENCY_OFFSET: keep_mask = `KEEP_NONE;
				`ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG: keep_mask = `KEEP_NONE;
				default: keep_mask = `KEEP_ALL;
			endcase
		end
	endfunction

	// Reset release through two flip-flops; power-on reset source
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	assign rst_n = rst_sync;

	// Two-stage synchronisers for pins, plus edge history
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 5'h00;
			ce_s <= 1'b0;
			scl_s <= 1'b0;
			sdi_s <= 1'b0;
			osc_s <= 1'b0;
			cloe_s <= 1'b0;
			scl_d <= 1'b0;
			osc_d <= 1'b0;
		end else if (clk_en) begin
			meta <= {spi_ce, spi_scl, spi_sdi, osc_in, clkout_pin_enable};
			ce_s <= meta[4];
			scl_s <= meta[3];
			sdi_s <= meta[2];
			osc_s <= meta[1];
			cloe_s <= meta[0];
			scl_d <= scl_s;
			osc_d <= osc_s;
		end
	end

	// Oscillator-stopped pin needs its own synchroniser
	reg ostop_meta, ostop_s;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ostop_meta <= 1'b0;
			ostop_s <= 1'b0;
		end else if (clk_en) begin
			ostop_meta <= osc_stopped;
			ostop_s <= ostop_meta;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign osc_rise = osc_s & ~osc_d;
	assign next_in = {in_shift[6:0], sdi_s};
	assign byte_done = ce_s & scl_rise & (bit_cnt == 3'h7);
	assign wr_strobe = byte_done & ~cmd_phase & ~is_read;
	assign is_reset_code = (next_in == `SOFTWARE_RESET_CODE);

	// Serial transfer: command byte, then data bytes with address increment
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 3'h0;
			in_shift <= 8'h00;
			out_shift <= 8'h00;
			cmd_phase <= 1'b1;
			is_read <= 1'b0;
			addr <= 4'h0;
		end else if (clk_en) begin
			if (!ce_s) begin
				bit_cnt <= 3'h0;
				cmd_phase <= 1'b1;
				is_read <= 1'b0;
			end else if (scl_rise) begin
				in_shift <= next_in;
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					if (cmd_phase) begin
						cmd_phase <= 1'b0;
						is_read <= next_in[7];
						addr <= next_in[3:0];
					end else begin
						addr <= addr + 4'h1;
					end
				end
			end else if (scl_fall) begin
				if (bit_cnt == 3'h0)
					out_shift <= regs[addr] & reg_mask(addr);
				else
					out_shift <= {out_shift[6:0], 1'b0};
			end
		end
	end

	assign sdo_out = out_shift[7];
	assign sdo_oe_n = ~(ce_s & is_read & ~cmd_phase);

	// Freeze counting while a time or date register is in use
	assign counters_frozen = ce_s & ~cmd_phase &
		(addr >= `ADDR_SECONDS_COUNT) & (addr <= `ADDR_YEAR_COUNT);

	// Register file: reset, host writes, counter loads and event flags
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i <= `ADDR_LAST; i = i + 1)
				regs[i] <= rst_value(i[3:0]);
			sw_reset_pending <= 1'b0;
			software_reset_pulse <= 1'b0;
		end else if (clk_en) begin
			software_reset_pulse <= sw_reset_pending;
			sw_reset_pending <= wr_strobe & (addr == `ADDR_MAIN_CONTROL) & is_reset_code;
			if (sw_reset_pending) begin
				for (i = 0; i <= `ADDR_LAST; i = i + 1)
					regs[i] <= (regs[i] & keep_mask(i[3:0])) | rst_value(i[3:0]);
			end else begin
				// Outside counting logic loads the time, except while frozen
				if (time_update & ~counters_frozen) begin
					regs[`ADDR_SECONDS_COUNT] <= {regs[`ADDR_SECONDS_COUNT][7], time_in[6:0]};
					for (i = 1; i < 7; i = i + 1)
						regs[`ADDR_SECONDS_COUNT + i] <= time_in[i*8 +: 8] & reg_mask(i[3:0] + `ADDR_SECONDS_COUNT);
				end
				if (wr_strobe) begin
					case (addr)
						`ADDR_MAIN_CONTROL: begin
							if (!is_reset_code)
								regs[addr] <= next_in & `MASK_MAIN_CONTROL;
						end
						`ADDR_INTERRUPT_CONTROL_STATUS: begin
							// Flags clear on a written 0, a written 1 leaves them
							regs[addr] <= (next_in & ~`FLAG_BITS_MASK) |
								(next_in & regs[addr] & `FLAG_BITS_MASK);
						end
						default: begin
							regs[addr] <= next_in & reg_mask(addr);
						end
					endcase
				end
			end
			// Events set flags; set wins over a clear or a software reset in the same cycle
			if (alarm_event)
				regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_ALARM_FLAG] <= 1'b1;
			if (countdown_event)
				regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_COUNTDOWN_FLAG] <= 1'b1;
			if (tick_event)
				regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_TICK_IRQ_FLAG] <= 1'b1;
			if (ostop_s)
				regs[`ADDR_SECONDS_COUNT][`BIT_OSCILLATOR_STOPPED_FLAG] <= 1'b1;
		end
	end

	// Field outputs
	assign external_clock_test_select = regs[`ADDR_MAIN_CONTROL][`BIT_EXTERNAL_CLOCK_TEST_SELECT];
	assign rtc_source_stopped = regs[`ADDR_MAIN_CONTROL][`BIT_CLOCK_STOP];
	assign hour_12_mode = regs[`ADDR_MAIN_CONTROL][`BIT_HOUR_12_MODE];
	assign minute_tick_irq_enable = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_MINUTE_TICK_IRQ_ENABLE];
	assign second_tick_irq_enable = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_SECOND_TICK_IRQ_ENABLE];
	assign tick_irq_flag = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_TICK_IRQ_FLAG];
	assign timer_irq_pulse_select = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_TIMER_IRQ_PULSE_SELECT];
	assign alarm_flag = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_ALARM_FLAG];
	assign countdown_flag = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_COUNTDOWN_FLAG];
	assign alarm_irq_enable = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_ALARM_IRQ_ENABLE];
	assign countdown_irq_enable = regs[`ADDR_INTERRUPT_CONTROL_STATUS][`BIT_COUNTDOWN_IRQ_ENABLE];
	assign time_value = {regs[`ADDR_YEAR_COUNT], regs[`ADDR_MONTH_COUNT], regs[`ADDR_DAY_OF_WEEK_COUNT],
		regs[`ADDR_DAY_OF_MONTH_COUNT], regs[`ADDR_HOURS_COUNT], regs[`ADDR_MINUTES_COUNT],
		regs[`ADDR_SECONDS_COUNT]};
	assign alarm_match = {regs[`ADDR_ALARM_DAY_OF_WEEK_MATCH], regs[`ADDR_ALARM_DAY_MATCH],
		regs[`ADDR_ALARM_HOUR_MATCH], regs[`ADDR_ALARM_MINUTE_MATCH]};
	assign frequency_offset = regs[`ADDR_FREQUENCY_OFFSET];
	assign clock_output_frequency_select = regs[`ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG][`COF_MSB:`COF_LSB];
	assign countdown_enable = regs[`ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG][`BIT_COUNTDOWN_ENABLE];
	assign countdown_source_select = regs[`ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG][`CTD_MSB:`CTD_LSB];
	assign countdown_value = regs[`ADDR_COUNTDOWN_VALUE];

	// Correction interrupt pulse, gated by its enable
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			correction_irq_pulse <= 1'b0;
		else if (clk_en)
			correction_irq_pulse <= correction_cycle & regs[`ADDR_MAIN_CONTROL][`BIT_CORRECTION_IRQ_ENABLE];
	end

	// Source divider; held cleared while the clock is stopped
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= {`DIV_WIDTH{1'b0}};
			min_cnt <= 6'h00;
			tick_4096 <= 1'b0;
			tick_64 <= 1'b0;
			tick_1 <= 1'b0;
			tick_60 <= 1'b0;
		end else if (clk_en) begin
			tick_4096 <= 1'b0;
			tick_64 <= 1'b0;
			tick_1 <= 1'b0;
			tick_60 <= 1'b0;
			if (rtc_source_stopped) begin
				div_cnt <= {`DIV_WIDTH{1'b0}};
				min_cnt <= 6'h00;
			end else if (osc_rise) begin
				div_cnt <= div_cnt + 15'h0001;
				tick_4096 <= ((div_cnt & `DIV_4096_MASK) == `DIV_4096_MASK);
				tick_64 <= ((div_cnt & `DIV_64_MASK) == `DIV_64_MASK);
				if (div_cnt == `DIV_1_MASK) begin
					tick_1 <= 1'b1;
					if (min_cnt == `MINUTE_LAST) begin
						min_cnt <= 6'h00;
						tick_60 <= 1'b1;
					end else begin
						min_cnt <= min_cnt + 6'h01;
					end
				end
			end
		end
	end

	// Countdown source selection and seconds tick
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			countdown_source_tick <= 1'b0;
			second_tick <= 1'b0;
		end else if (clk_en) begin
			second_tick <= tick_1;
			case (countdown_source_select)
				`CTD_4096: countdown_source_tick <= countdown_enable & tick_4096;
				`CTD_64: countdown_source_tick <= countdown_enable & tick_64;
				`CTD_1: countdown_source_tick <= countdown_enable & tick_1;
				default: countdown_source_tick <= countdown_enable & tick_60;
			endcase
		end
	end

	// Clock output prescaler runs free, independent of the stop bit
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			cko_cnt <= 2'h0;
		else if (clk_en && osc_rise)
			cko_cnt <= cko_cnt + 2'h1;
	end

	// Clock output level per frequency select
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_level <= 1'b1;
		end else if (clk_en) begin
			case (clock_output_frequency_select)
				`COF_32768: clk_level <= osc_s;
				`COF_16384: clk_level <= cko_cnt[0];
				`COF_8192: clk_level <= cko_cnt[1];
				`COF_4096: clk_level <= div_cnt[2];
				`COF_1024: clk_level <= div_cnt[4];
				`COF_32: clk_level <= div_cnt[9];
				`COF_1: clk_level <= div_cnt[14];
				default: clk_level <= 1'b1;
			endcase
		end
	end

	// Open-drain clock output: pulls low only, released when disabled
	assign clkout_out = 1'b0;
	assign clkout_oe_n = ~(cloe_s & ~clk_level);

endmodule

// ===== rtc_register_bank_bench.sv
// Self-checking bench for the clock register bank
`include "rtc_register_map.vh"
module rtc_register_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, resetn, spi_ce, spi_scl, spi_sdi, osc_in, osc_stopped, clkout_pin_enable, time_update;
	logic alarm_event, countdown_event, tick_event, correction_cycle, rd_valid;
	logic corr_on, cie_exp, corr_d;
	logic [55:0] time_in;
	logic [7:0] rd_byte, sec, mnt, hr, day, wd, mon, yr;
	logic [7:0] expq[$];
	int mismatches, total_checks, osc_cnt;
	wire sdo_out, sdo_oe_n, counters_frozen, corr_pulse;

	rtc_register_bank rtc_register_bank_i (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .spi_ce(spi_ce),
		.spi_scl(spi_scl), .spi_sdi(spi_sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .osc_in(osc_in),
		.osc_stopped(osc_stopped), .clkout_pin_enable(clkout_pin_enable), .clkout_out(), .clkout_oe_n(),
		.time_update(time_update), .time_in(time_in), .alarm_event(alarm_event), .countdown_event(countdown_event),
		.tick_event(tick_event), .correction_cycle(correction_cycle), .correction_irq_pulse(corr_pulse),
		.time_value(),
		.counters_frozen(counters_frozen), .software_reset_pulse(), .external_clock_test_select(),
		.rtc_source_stopped(), .hour_12_mode(), .minute_tick_irq_enable(), .second_tick_irq_enable(),
		.timer_irq_pulse_select(), .alarm_irq_enable(), .countdown_irq_enable(), .alarm_flag(), .countdown_flag(),
		.tick_irq_flag(), .alarm_match(), .frequency_offset(), .clock_output_frequency_select(),
		.countdown_enable(), .countdown_source_select(), .countdown_value(), .countdown_source_tick(),
		.second_tick());
	spi_host_model host_i (.core_clk(core_clk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .spi_ce(spi_ce),
		.spi_scl(spi_scl), .spi_sdi(spi_sdi), .rd_valid(rd_valid), .rd_byte(rd_byte));

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Oscillator square wave and random correction cycles
	always @(posedge core_clk) begin
		osc_cnt <= osc_cnt + 1;
		osc_in <= osc_cnt[2];
		correction_cycle <= corr_on && (($urandom % 8) == 0);
	end
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
		host_i.start({4'h0, a});
		foreach (d[i]) host_i.shift_byte(d[i]);
		host_i.stop();
	endtask
	// Burst read; expectations queued before the bytes come back
	task automatic rd(input logic [3:0] a, input logic [7:0] e[$]);
		foreach (e[i]) expq.push_back(e[i]);
		host_i.start({4'h8, a});
		foreach (e[i]) host_i.shift_byte(8'h00);
		host_i.stop();
	endtask
	task test_done();
		if (expq.size() != 0)
			mismatches++;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Oldest expectation against each returned byte
	always @(posedge core_clk) begin
		if (rd_valid === 1'b1)
			check_byte(rd_byte, expq.size() > 0 ? expq.pop_front() : 8'hxx);
	end
	// Correction pulse one cycle after each correction cycle, only while enabled
	always @(posedge core_clk) begin
		corr_d <= correction_cycle & cie_exp;
		if (resetn === 1'b1)
			check_byte({7'h00, corr_pulse}, {7'h00, corr_d});
	end
	// Hang guard
	initial begin
		#300us;
		mismatches++;
		test_done();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h622da700));
		{resetn, osc_stopped, clkout_pin_enable, time_update, time_in} = '0;
		{alarm_event, countdown_event, tick_event, cie_exp} = '0;
		corr_on = 1'b1;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(4'h0, '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80,
			8'h00, 8'h03, 8'h00});
		clkout_pin_enable <= 1'b1;
		wr(4'hf, '{8'h5a, 8'h14});
		rd(4'hf, '{8'h5a, 8'h04});
		wr(4'h1, '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
			8'hff, 8'hff});
		rd(4'h1, '{8'hd3, 8'h7f, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h1f, 8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'hff,
			8'h7b, 8'hff});
		// Status events, then writing ones keeps flags and zeros clear them
		@(posedge core_clk);
		{alarm_event, countdown_event, tick_event} <= 3'b111;
		@(posedge core_clk);
		{alarm_event, countdown_event, tick_event} <= 3'b000;
		wr(4'h1, '{8'hff});
		rd(4'h1, '{8'hff});
		wr(4'h1, '{8'hd3});
		rd(4'h1, '{8'hd3});
		// Oscillator stop raises the seconds flag
		@(posedge core_clk);
		osc_stopped <= 1'b1;
		repeat (8) @(posedge core_clk);
		osc_stopped <= 1'b0;
		rd(4'h2, '{8'hff});
		// Random time load, then a second load that arrives while frozen
		sec = bcd($urandom % 60);
		mnt = bcd($urandom % 60);
		hr = bcd($urandom % 24);
		day = bcd(1 + $urandom % 31);
		wd = bcd($urandom % 7);
		mon = bcd(1 + $urandom % 12);
		yr = bcd($urandom % 100);
		@(posedge core_clk);
		time_in <= {yr, mon, wd, day, hr, mnt, sec};
		time_update <= 1'b1;
		@(posedge core_clk);
		time_update <= 1'b0;
		fork
			rd(4'h2, '{8'h80 | sec, mnt, hr, day, wd, mon, yr});
			begin
				for (int i = 0; i < 400 && counters_frozen !== 1'b1; i++) @(posedge core_clk);
				time_in <= 56'h0;
				time_update <= 1'b1;
				@(posedge core_clk);
				time_update <= 1'b0;
			end
		join
		wr(4'h0, '{`SOFTWARE_RESET_CODE});
		rd(4'h0, '{8'h00, 8'h00, 8'h80 | sec, mnt, hr, day, wd, mon, yr, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h00,
			8'h03, 8'hff});
		corr_on <= 1'b0;
		wr(4'h0, '{8'h02});
		cie_exp <= 1'b1;
		corr_on <= 1'b1;
		repeat (200) @(posedge core_clk);
		rd(4'h0, '{8'h02});
		repeat (20) @(posedge core_clk);
		test_done();
	end
endmodule

// ===== rtc_register_bank_checker.sv
// Port assertions for the clock register bank
module rtc_register_bank_checker (
	input wire core_clk,
	input wire resetn,
	input wire spi_ce,
	input wire sdo_oe_n,
	input wire osc_stopped,
	input wire clkout_pin_enable,
	input wire clkout_oe_n,
	input wire time_update,
	input wire alarm_event,
	input wire correction_cycle,
	input wire correction_irq_pulse,
	input wire [55:0] time_value,
	input wire counters_frozen,
	input wire software_reset_pulse,
	input wire hour_12_mode,
	input wire minute_tick_irq_enable,
	input wire second_tick_irq_enable,
	input wire alarm_irq_enable,
	input wire countdown_irq_enable,
	input wire alarm_flag,
	input wire [31:0] alarm_match,
	input wire [7:0] frequency_offset,
	input wire [2:0] clock_output_frequency_select,
	input wire countdown_enable,
	input wire countdown_source_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Multi-cycle held conditions seen through the pin synchronisers
	sequence ce_idle;
		!spi_ce [*4];
	endsequence
	sequence stop_held;
		osc_stopped [*4];
	endsequence
	// Bus, reset and flag relations
	a_sdo_released: assert property (ce_idle |-> sdo_oe_n) else $error("sdo driven outside a frame");
	a_corr_gated: assert property (correction_irq_pulse |-> $past(correction_cycle)) else $error("stray correction pulse");
	a_srst_single: assert property (software_reset_pulse |=> !software_reset_pulse) else $error("reset pulse too long");
	a_srst_modes: assert property (software_reset_pulse |-> (frequency_offset == 8'h00 && !hour_12_mode
		&& clock_output_frequency_select == 3'h0)) else $error("modes not reset");
	a_srst_disables: assert property (software_reset_pulse |-> (alarm_match[31] && alarm_match[23]
		&& alarm_match[15] && alarm_match[7] && !countdown_enable && !alarm_irq_enable && !countdown_irq_enable
		&& !minute_tick_irq_enable && !second_tick_irq_enable)) else $error("sources still enabled");
	a_alarm_sets: assert property (alarm_event |=> alarm_flag) else $error("alarm flag not set");
	a_alarm_holds: assert property ($fell(alarm_flag) |-> $past(spi_ce)) else $error("alarm flag lost");
	a_stop_flag: assert property (stop_held |-> time_value[7]) else $error("stopped flag clear");
	a_freeze_time: assert property (counters_frozen && time_update |=> time_value == $past(time_value))
		else $error("time moved while frozen");
	a_clkout_off: assert property (!clkout_pin_enable [*4] |-> clkout_oe_n) else $error("clock output driven");
	a_tick_gated: assert property (!countdown_enable [*3] |-> !countdown_source_tick) else $error("stray tick");
endmodule

bind rtc_register_bank rtc_register_bank_checker rtc_register_bank_checker_i (.core_clk(core_clk), .resetn(resetn),
	.spi_ce(spi_ce), .sdo_oe_n(sdo_oe_n), .osc_stopped(osc_stopped), .clkout_pin_enable(clkout_pin_enable),
	.clkout_oe_n(clkout_oe_n), .time_update(time_update), .alarm_event(alarm_event),
	.correction_cycle(correction_cycle), .correction_irq_pulse(correction_irq_pulse), .time_value(time_value),
	.counters_frozen(counters_frozen), .software_reset_pulse(software_reset_pulse), .hour_12_mode(hour_12_mode),
	.minute_tick_irq_enable(minute_tick_irq_enable), .second_tick_irq_enable(second_tick_irq_enable),
	.alarm_irq_enable(alarm_irq_enable), .countdown_irq_enable(countdown_irq_enable), .alarm_flag(alarm_flag),
	.alarm_match(alarm_match), .frequency_offset(frequency_offset),
	.clock_output_frequency_select(clock_output_frequency_select), .countdown_enable(countdown_enable),
	.countdown_source_tick(countdown_source_tick));

// ===== rtc_register_map.vh
// Register offsets, field positions, masks and reset values of the clock register bank
`ifndef RTC_REGISTER_MAP_VH
`define RTC_REGISTER_MAP_VH

`define ADDR_MAIN_CONTROL 4'h0
`define ADDR_INTERRUPT_CONTROL_STATUS 4'h1
`define ADDR_SECONDS_COUNT 4'h2
`define ADDR_MINUTES_COUNT 4'h3
`define ADDR_HOURS_COUNT 4'h4
`define ADDR_DAY_OF_MONTH_COUNT 4'h5
`define ADDR_DAY_OF_WEEK_COUNT 4'h6
`define ADDR_MONTH_COUNT 4'h7
`define ADDR_YEAR_COUNT 4'h8
`define ADDR_ALARM_MINUTE_MATCH 4'h9
`define ADDR_ALARM_HOUR_MATCH 4'ha
`define ADDR_ALARM_DAY_MATCH 4'hb
`define ADDR_ALARM_DAY_OF_WEEK_MATCH 4'hc
`define ADDR_FREQUENCY_OFFSET 4'hd
`define ADDR_TIMER_AND_CLOCK_OUTPUT_CONFIG 4'he
`define ADDR_COUNTDOWN_VALUE 4'hf
`define ADDR_LAST 4'hf

// Main control fields
`define BIT_EXTERNAL_CLOCK_TEST_SELECT 7
`define BIT_CLOCK_STOP 5
`define BIT_HOUR_12_MODE 2
`define BIT_CORRECTION_IRQ_ENABLE 1
`define SOFTWARE_RESET_CODE 8'h58

// Interrupt control and status fields
`define BIT_MINUTE_TICK_IRQ_ENABLE 7
`define BIT_SECOND_TICK_IRQ_ENABLE 6
`define BIT_TICK_IRQ_FLAG 5
`define BIT_TIMER_IRQ_PULSE_SELECT 4
`define BIT_ALARM_FLAG 3
`define BIT_COUNTDOWN_FLAG 2
`define BIT_ALARM_IRQ_ENABLE 1
`define BIT_COUNTDOWN_IRQ_ENABLE 0
`define FLAG_BITS_MASK 8'h2c

// Seconds and clock output fields
`define BIT_OSCILLATOR_STOPPED_FLAG 7
`define COF_MSB 6
`define COF_LSB 4
`define BIT_COUNTDOWN_ENABLE 3
`define CTD_MSB 1
`define CTD_LSB 0

// Implemented bits of each register
`define MASK_MAIN_CONTROL 8'ha6
`define MASK_FULL 8'hff
`define MASK_MINUTES 8'h7f
`define MASK_HOURS 8'h3f
`define MASK_DAYS 8'h3f
`define MASK_WEEKDAYS 8'h07
`define MASK_MONTHS 8'h1f
`define MASK_HOUR_ALARM 8'hbf
`define MASK_DAY_ALARM 8'hbf
`define MASK_WEEKDAY_ALARM 8'h87
`define MASK_TIMER_CONFIG 8'h7b

// Reset values and bits that a software reset leaves untouched
`define RST_ZERO 8'h00
`define RST_SECONDS 8'h80
`define RST_ALARM 8'h80
`define RST_TIMER_CONFIG 8'h03
`define KEEP_NONE 8'h00
`define KEEP_ALL 8'hff
`define KEEP_ALARM 8'h7f

// Divider taps on the 32.768 kHz edge count
`define DIV_WIDTH 15
`define DIV_4096_MASK 15'h0007
`define DIV_64_MASK 15'h01ff
`define DIV_1_MASK 15'h7fff
`define MINUTE_LAST 6'h3b
`define COF_32768 3'h0
`define COF_16384 3'h1
`define COF_8192 3'h2
`define COF_4096 3'h3
`define COF_1024 3'h4
`define COF_32 3'h5
`define COF_1 3'h6
`define CTD_4096 2'h0
`define CTD_64 2'h1
`define CTD_1 2'h2

`endif

// ===== spi_host_model.sv
// Behavioural host on the serial register bus
module spi_host_model #(
	parameter int HALF = 6
) (
	input wire logic core_clk,
	input wire logic sdo_out,
	input wire logic sdo_oe_n,
	output logic spi_ce,
	output logic spi_scl,
	output logic spi_sdi,
	output logic rd_valid,
	output logic [7:0] rd_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_mode;
	// Idle bus: CE low, SCL standing still
	initial begin
		spi_ce = 1'b0;
		spi_scl = 1'b0;
		spi_sdi = 1'b0;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
		rd_mode = 1'b0;
	end
	// Read strobe lasts one cycle
	always @(posedge core_clk) begin
		if (rd_valid)
			rd_valid <= 1'b0;
	end
	// One byte MSB first; SDI moves with SCL low, SDO taken at the rise
	task automatic shift_byte(input logic [7:0] d);
		logic [7:0] q;
		for (int i = 7; i >= 0; i--) begin
			@(posedge core_clk);
			spi_scl <= 1'b0;
			spi_sdi <= d[i];
			repeat (HALF) @(posedge core_clk);
			spi_scl <= 1'b1;
			q[i] = sdo_oe_n ? 1'bx : sdo_out;
			repeat (HALF - 1) @(posedge core_clk);
		end
		if (rd_mode) begin
			rd_byte <= q;
			rd_valid <= 1'b1;
		end
	endtask
	// Frame opening and command byte
	task automatic start(input logic [7:0] cmd);
		@(posedge core_clk);
		spi_ce <= 1'b1;
		rd_mode = 1'b0;
		repeat (HALF) @(posedge core_clk);
		shift_byte(cmd);
		rd_mode = cmd[7];
	endtask
	// Frame close; released data line shows the inverse of its last level
	task automatic stop();
		@(posedge core_clk);
		spi_scl <= 1'b0;
		repeat (HALF) @(posedge core_clk);
		spi_ce <= 1'b0;
		spi_sdi <= ~spi_sdi;
		repeat (2 * HALF) @(posedge core_clk);
	endtask
endmodule
